// >>> hw/period_pkg.sv
package period_pkg;

   // Counter and register widths.
   localparam int CNT_W = 12;
   localparam int REG_W = 8;
   localparam int CAP_W = 16;

   // Register addresses on the 5-bit register port.
   localparam logic [4:0] ADDR_ALIGN_LATCH = 5'h07;
   localparam logic [4:0] ADDR_CAPTURE = 5'h06;
   localparam logic [4:0] ADDR_START_LOW = 5'h0a;
   localparam logic [4:0] ADDR_START_HIGH = 5'h0b;

   // Align/latch control bit positions.
   localparam int BIT_RESTART = 0;
   localparam int BIT_CAPTURE = 1;

   // Default start values per output-rate code, core clock 4.096 MHz.
   localparam logic [11:0] START_8K = 12'h1ff;
   localparam logic [11:0] START_4K = 12'h3ff;
   localparam logic [11:0] START_2K = 12'h7ff;
   localparam logic [11:0] START_1K = 12'hfff;

   // Output-ready low time in core clock cycles.
   localparam logic [6:0] READY_LOW_CYCLES = 7'h40;

   // Reset values.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [11:0] RESET_COUNT = 12'hfff;

   // Register write strobe with its address and data.
   typedef struct packed {
      logic valid;
      logic [4:0] addr;
      logic [7:0] data;
   } reg_write_type;

endpackage

// >>> hw/ready_pulse.sv
`timescale 1ns/100ps
`default_nettype none

module ready_pulse
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Period start and pin mode.
   input wire logic period_start,
   input wire logic clock_out_mode,
   // Active-low output-ready strobe.
   output logic output_ready_strobe_b
);

   logic [6:0] cnt_q;
   logic [6:0] cnt_d;

   // Loads the low-time counter at each period start and counts it out.
   always_comb
   begin
      cnt_d = cnt_q;
      if (period_start)
         cnt_d = period_pkg::READY_LOW_CYCLES;
      else if (cnt_q != 7'h00)
         cnt_d = cnt_q - 7'h01;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= 7'h00;
      else
         cnt_q <= cnt_d;
   end

   assign output_ready_strobe_b = clock_out_mode | (cnt_q == 7'h00);

   a_ready_low_width: assert property (@(posedge clk) disable iff (!rst_b)
      (period_start && !clock_out_mode) |=> (!output_ready_strobe_b [*8]))
      else $error("Output-ready did not stay low after period start.");

endmodule

`default_nettype wire

// >>> hw/period_counter.sv
`timescale 1ns/100ps
`default_nettype none

module period_counter
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Register write port, already deserialised and synchronous to clk.
   input wire period_pkg::reg_write_type wr,
   // Register read port.
   input wire logic [4:0] rd_addr,
   output logic [15:0] rd_data,
   // Configuration from the configuration register.
   input wire logic [1:0] output_rate_select,
   input wire logic clock_out_mode,
   // Period status.
   output logic period_start,
   output logic [11:0] count,
   output logic output_ready_strobe_b
);

   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   logic [11:0] cap_q;
   logic [11:0] cap_d;
   logic [7:0] low_q;
   logic [7:0] low_d;
   logic [3:0] high_q;
   logic [3:0] high_d;
   logic [1:0] ctl_q;
   logic [1:0] ctl_d;
   logic pend_q;
   logic pend_d;
   logic [11:0] default_start;
   logic wr_ctl;
   logic [15:0] rd_data_d;
   logic [15:0] rd_data_q;

   always_comb
   begin
      case (output_rate_select)
         2'b00: default_start = period_pkg::START_8K;
         2'b01: default_start = period_pkg::START_4K;
         2'b10: default_start = period_pkg::START_2K;
         2'b11: default_start = period_pkg::START_1K;
         default: default_start = period_pkg::START_8K;
      endcase
   end

   assign wr_ctl = wr.valid && (wr.addr == period_pkg::ADDR_ALIGN_LATCH);

   // Command bits set on write and fall back to zero the next cycle.
   always_comb
   begin
      ctl_d = 2'b00;
      if (wr_ctl)
         ctl_d = wr.data[1:0];
   end

   // Start-value bytes; a high-byte write arms the pending load.
   always_comb
   begin
      low_d = low_q;
      high_d = high_q;
      pend_d = pend_q;
      if (wr.valid && wr.addr == period_pkg::ADDR_START_LOW)
         low_d = wr.data;
      if (wr.valid && wr.addr == period_pkg::ADDR_START_HIGH)
      begin
         high_d = wr.data[3:0];
         pend_d = 1'b1;
      end
      else if (period_start && !ctl_q[period_pkg::BIT_RESTART])
         pend_d = 1'b0;
   end

   // Period boundary: zero reached or immediate restart.
   // immediate restart
   assign period_start = (cnt_q == 12'h000) || ctl_q[period_pkg::BIT_RESTART];

   // Down-counter.
   always_comb
   begin
      cnt_d = cnt_q - 12'h001;
      if (period_start)
      begin
         if (pend_q && !ctl_q[period_pkg::BIT_RESTART])
            cnt_d = {high_q, low_q};
         else
            cnt_d = default_start;
      end
   end

   // Capture register.
   always_comb
   begin
      cap_d = cap_q;
      if (ctl_q[period_pkg::BIT_CAPTURE])
         cap_d = cnt_q;
   end

   // Registered read data.
   always_comb
   begin
      case (rd_addr)
         period_pkg::ADDR_CAPTURE: rd_data_d = {4'h0, cap_q};
         period_pkg::ADDR_ALIGN_LATCH: rd_data_d = {14'h0000, ctl_q};
         period_pkg::ADDR_START_LOW: rd_data_d = {8'h00, low_q};
         period_pkg::ADDR_START_HIGH: rd_data_d = {12'h000, high_q};
         default: rd_data_d = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= period_pkg::RESET_COUNT;
         cap_q <= 12'h000;
         low_q <= period_pkg::RESET_BYTE;
         high_q <= 4'h0;
         ctl_q <= 2'b00;
         pend_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end
      else
      begin
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         low_q <= low_d;
         high_q <= high_d;
         ctl_q <= ctl_d;
         pend_q <= pend_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_data = rd_data_q;
   assign count = cnt_q;

   // Output-ready pulse generator.
   ready_pulse u_ready
   (
      .clk(clk),
      .rst_b(rst_b),
      .period_start(period_start),
      .clock_out_mode(clock_out_mode),
      .output_ready_strobe_b(output_ready_strobe_b)
   );

   // Cycles since the last period start, saturating; only the checks below read it.
   logic [6:0] since_q;
   logic [6:0] since_d;

   // Restarts the helper count at every period start and stops it at its top value.
   always_comb
   begin
      since_d = since_q;
      if (period_start)
         since_d = 7'h00;
      else if (since_q != 7'h7f)
         since_d = since_q + 7'h01;
   end

   // Reset leaves the helper saturated, so no ready pulse is expected after it.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         since_q <= 7'h7f;
      else
         since_q <= since_d;
   end

   a_rate_start: assert property (@(posedge clk) disable iff (!rst_b)
      (period_start && !pend_q && !ctl_q[0]) |=> (cnt_q == $past(default_start)))
      else $error("Default start value wrong after period end.");

   a_capture_copy: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_ctl && wr.data == 8'h02) |=> ##1 (cap_q == $past(cnt_q)))
      else $error("Capture did not copy the counter.");

   a_capture_hold: assert property (@(posedge clk) disable iff (!rst_b)
      (!ctl_q[period_pkg::BIT_CAPTURE]) |=> (cap_q == $past(cap_q)))
      else $error("Capture register changed without a capture request.");

   a_capture_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (ctl_q[1] && !wr_ctl) |=> !ctl_q[1])
      else $error("Capture bit did not clear itself.");

   a_read_align: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_addr == period_pkg::ADDR_ALIGN_LATCH) |=> (rd_data == {14'h0000, $past(ctl_q)}))
      else $error("Align/latch read data wrong.");

   a_capture_upper: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_addr == period_pkg::ADDR_CAPTURE) |=> (rd_data == {4'h0, $past(cap_q)}))
      else $error("Capture read data wrong.");

   a_command_bits: assert property (@(posedge clk) disable iff (!rst_b)
      wr_ctl |=> (ctl_q == $past(wr.data[1:0])))
      else $error("Command bits did not follow the write.");

   a_restart_now: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_ctl && wr.data == 8'h01) |=> ##1 (cnt_q == $past(default_start)))
      else $error("Restart did not reload the counter.");

   a_load_value: assert property (@(posedge clk) disable iff (!rst_b)
      (pend_q && cnt_q == 12'h000 && !ctl_q[0] && !wr.valid)
      |=> (cnt_q == {high_q, low_q}))
      else $error("Loaded start value not used.");

   a_low_byte_store: assert property (@(posedge clk) disable iff (!rst_b)
      (wr.valid && wr.addr == period_pkg::ADDR_START_LOW) |=> (low_q == $past(wr.data)))
      else $error("Low start byte not stored.");

   a_high_byte_store: assert property (@(posedge clk) disable iff (!rst_b)
      (wr.valid && wr.addr == period_pkg::ADDR_START_HIGH)
      |=> (high_q == $past(wr.data[3:0]) && pend_q))
      else $error("High start byte not stored or load not armed.");

   a_read_start_low: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_addr == period_pkg::ADDR_START_LOW) |=> (rd_data == {8'h00, $past(low_q)}))
      else $error("Low start byte read data wrong.");

   a_read_start_high: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_addr == period_pkg::ADDR_START_HIGH) |=> (rd_data == {12'h000, $past(high_q)}))
      else $error("High start byte read data wrong.");

   a_pend_consumed: assert property (@(posedge clk) disable iff (!rst_b)
      (pend_q && period_start && !ctl_q[0]
      && !(wr.valid && wr.addr == period_pkg::ADDR_START_HIGH)) |=> !pend_q)
      else $error("Pending load not consumed at the period end.");

   a_pend_survives: assert property (@(posedge clk) disable iff (!rst_b)
      (pend_q && ctl_q[period_pkg::BIT_RESTART]) |=> pend_q)
      else $error("Restart dropped the pending load.");

   a_restart_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (ctl_q[0] && !wr_ctl) |=> !ctl_q[0])
      else $error("Restart bit did not clear itself.");

   // one count per clock; the release edge itself is not armed.
   a_count_down: assert property (@(posedge clk) disable iff (!rst_b)
      (rst_b && !period_start) |=> (cnt_q == $past(cnt_q) - 12'h001))
      else $error("Counter did not decrement.");

   a_ready_full_width: assert property (@(posedge clk) disable iff (!rst_b)
      output_ready_strobe_b == (clock_out_mode || since_q >= period_pkg::READY_LOW_CYCLES))
      else $error("Output-ready low time wrong.");

   // Main scenarios: capture, restart, load, a whole ready pulse and a set-wins write.
   c_capture: cover property (@(posedge clk) disable iff (!rst_b) ctl_q[1]);
   c_restart: cover property (@(posedge clk) disable iff (!rst_b) ctl_q[0]);
   c_load: cover property (@(posedge clk) disable iff (!rst_b) pend_q && cnt_q == 12'h000);
   c_ready_done: cover property (@(posedge clk) disable iff (!rst_b)
      since_q == period_pkg::READY_LOW_CYCLES && !clock_out_mode);
   c_set_wins: cover property (@(posedge clk) disable iff (!rst_b)
      period_start && wr.valid && wr.addr == period_pkg::ADDR_START_HIGH);

endmodule

`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model
(
   // Clock.
   input wire logic clk,
   // Register ports of the device.
   output var period_pkg::reg_write_type wr,
   output logic [4:0] rd_addr,
   input wire logic [15:0] rd_data
);
   // Lock register address; the value is arbitrary and unmapped in this block.
   localparam logic [4:0] LOCK_ADDR = 5'h1f;

   // The bus is idle until the first request.
   initial
   begin
      wr = '0;
      rd_addr = 5'h00;
   end

   // One byte write; data is scrambled once the strobe drops.
   task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= '{valid: 1'b1, addr: a, data: d};
      @(posedge clk);
      wr <= '{valid: 1'b0, addr: ~a, data: ~d};
   endtask

   // Read data arrives one cycle after the address is driven.
   task automatic read_reg(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk);
      rd_addr <= a;
      @(posedge clk);
      #1 v = rd_data;
   endtask

   task automatic load_start(input logic [11:0] v);
      write_byte(period_pkg::ADDR_START_LOW, v[7:0]);
      write_byte(period_pkg::ADDR_START_HIGH, {4'h0, v[11:8]});
   endtask

   // lock key writes; the lock register sits outside this block.
   task automatic set_lock(input logic [7:0] key);
      write_byte(LOCK_ADDR, key);
   endtask

   function automatic logic [11:0] new_start(input logic [11:0] x, c0, y);
      return (y > x) ? x + c0 - y : x - y;
   endfunction
endmodule

`default_nettype wire

// >>> tb/adc_period_counter_sync_bench.sv
`timescale 1ns/100ps
`default_nettype none

module adc_period_counter_sync_bench;
   logic clk;
   logic rst_b;
   logic [1:0] rate;
   logic clk_out;
   period_pkg::reg_write_type wr;
   logic [4:0] rd_addr;
   logic [15:0] rd_data;
   logic period_start;
   logic [11:0] count;
   logic ready_b;
   logic [15:0] v;
   logic [11:0] snap;
   int fail_count;
   int n_tests;
   int cycles;

   period_counter dut (.clk(clk), .rst_b(rst_b), .wr(wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .output_rate_select(rate), .clock_out_mode(clk_out),
      .period_start(period_start), .count(count), .output_ready_strobe_b(ready_b));
   host_model host (.clk(clk), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data));

   // Free-running core clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Returns just after the edge that shows a period start.
   task automatic wait_period();
      repeat (5000)
      begin
         @(posedge clk);
         #1;
         if (period_start === 1'b1)
            break;
      end
   endtask

   // Restart under every rate code.
   task automatic t_rates();
      logic [11:0] st [4] = '{12'h1ff, 12'h3ff, 12'h7ff, 12'hfff};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         rate <= i[1:0];
         host.write_byte(period_pkg::ADDR_ALIGN_LATCH, 8'h01);
         #1 check({15'h0, period_start}, 16'h0001);
         @(posedge clk);
         #1 check({4'h0, count}, {4'h0, st[i]});
         host.read_reg(period_pkg::ADDR_ALIGN_LATCH, v);
         check(v, 16'h0000);
      end
   endtask

   // Snapshot matches the live count; writes to it are ignored.
   task automatic t_capture();
      host.set_lock(8'h9c);
      host.write_byte(period_pkg::ADDR_ALIGN_LATCH, 8'h02);
      #1 snap = count;
      host.read_reg(period_pkg::ADDR_CAPTURE, v);
      check(v, {4'h0, snap});
      host.read_reg(period_pkg::ADDR_ALIGN_LATCH, v);
      check(v, 16'h0000);
      host.write_byte(period_pkg::ADDR_CAPTURE, 8'h55);
      host.read_reg(period_pkg::ADDR_CAPTURE, v);
      check(v, {4'h0, snap});
   endtask

   // Loaded start applies at the next zero, then the default returns.
   task automatic t_load();
      logic [11:0] ns;
      ns = host.new_start(12'h100, 12'h1ff, 12'h180);
      @(posedge clk);
      rate <= 2'b00;
      host.write_byte(period_pkg::ADDR_ALIGN_LATCH, 8'h01);
      // load right after the period start.
      host.load_start(ns);
      host.read_reg(period_pkg::ADDR_START_LOW, v);
      check(v, {8'h00, ns[7:0]});
      host.read_reg(period_pkg::ADDR_START_HIGH, v);
      check(v, {12'h000, ns[11:8]});
      host.set_lock(8'hca);
      wait_period();
      @(posedge clk);
      #1 check({4'h0, count}, {4'h0, ns});
      @(posedge clk);
      #1 check({4'h0, count}, {4'h0, ns - 12'h001});
      wait_period();
      @(posedge clk);
      #1 check({4'h0, count}, 16'h01ff);
   endtask

   // Counts low cycles of the ready strobe after a restart.
   task automatic t_ready(input logic mode, input logic [15:0] exp);
      logic [15:0] lows;
      lows = 16'h0000;
      repeat (70) @(posedge clk);
      clk_out <= mode;
      host.write_byte(period_pkg::ADDR_ALIGN_LATCH, 8'h01);
      repeat (100)
      begin
         @(posedge clk);
         #1 lows = lows + {15'h0, ready_b === 1'b0};
      end
      check(lows, exp);
   endtask

   // Main sequence.
   initial
   begin
      rst_b = 1'b0;
      rate = 2'b11;
      clk_out = 1'b0;
      fail_count = 0;
      n_tests = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      check({4'h0, count}, 16'h0fff);
      rst_b <= 1'b1;
      t_rates();
      t_capture();
      t_load();
      t_ready(1'b0, 16'h0040);
      t_ready(1'b1, 16'h0000);
      report_and_stop();
   end
endmodule

`default_nettype wire
